// file: core/atb_trim_bank.sv
// analog die trim register bank, device end of the die-to-die link
//
// What this block does
// - four trim registers at 0xf0..0xf3, last adc offset
// - decode offsets at base 0x200 and 0x300
// - 8-bit read/write, first register resets zero
// - contents held through low-power mode
// - reset returns every register to default
// - locked sleep-bandgap trim survives reset
// - software copies flash bytes 0x40c0..3 in order
// - software copies whole bytes, not fields
// - software opens protected flash via page index
// - startup copy preferably two 16-bit words
// - software masks lock bit when loading
// - lin slope bit acts only when enabled
// - watchdog code acts only when enabled
// - watchdog codes map to listed percentages
// - lock freezes analog sleep trim until power-down
// - sleep field and lock load only when enabled
// - bandgap slope bits act only when enabled
// - adc offset code acts only when enabled
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module atb_trim_bank (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_i,
  input wire logic ce_i,
  atb_d2d_if.dev link,
  output logic lin_slope_trim_o,
  output logic [2:0] watchdog_clock_trim_code_o,
  output logic signed [7:0] watchdog_clock_adjust_pct_o,
  output logic bandgap_slope_up_o,
  output logic bandgap_slope_down_o,
  output logic [2:0] iref_trim_code_o,
  output logic [2:0] sleep_bandgap_trim_code_o,
  output logic sleep_bandgap_locked_o,
  output logic [2:0] adc_offset_trim_code_o
);
  // {hit, index} for a link address
  function automatic logic [2:0] trim_decode(input logic [15:0] a);
    logic hit;
    hit = (a[15:8] == atb_pkg::BASE_BLOCKING[15:8] || a[15:8] == atb_pkg::BASE_NONBLOCKING[15:8])
          && (a[7:2] == atb_pkg::OFS_LIN_WD[7:2]);
    trim_decode = {hit, a[1:0]};
  endfunction : trim_decode

  logic [7:0] trim_r [0:atb_pkg::TRIM_COUNT-1];
  logic ack_r;
  logic err_r;
  logic [15:0] rdata_r;
  logic [2:0] ana_code_r;
  logic ana_lock_r;
  logic [2:0] slp_code_r;
  logic slp_locked_r;
  logic signed [7:0] wd_pct_r;
  logic [2:0] dec;
  logic [1:0] idx;
  logic [1:0] idx_odd;
  logic bad;
  logic take;

  assign dec = trim_decode(link.addr);
  assign idx = dec[1:0];
  assign idx_odd = {dec[1], 1'b1};
  // unmapped address, or a word access that is not word aligned
  assign bad = ~dec[2] | (link.wide & dec[0]);
  assign take = ce_i & link.req & ~ack_r;

  // one-cycle answer to every request, blocking and non-blocking alike
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_r <= take;
      err_r <= take & bad;
    end
  end

  // read data: word reads return the even register high, odd register low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_r <= 16'h0000;
    else if (take & ~link.we)
    begin
      if (bad)
        rdata_r <= 16'h0000;
      else if (link.wide)
        rdata_r <= {trim_r[idx], trim_r[idx_odd]};
      else
        rdata_r <= {8'h00, trim_r[idx]};
    end
  end

  assign link.ack = ack_r;
  assign link.err = err_r;
  assign link.rdata = rdata_r;

  // trim registers, one per offset
  genvar k;
  generate
    for (k = 0; k < atb_pkg::TRIM_COUNT; k++)
    begin : g_trim
      logic hit_k;
      logic wr_k;
      logic [7:0] data_k;
      logic [7:0] mask_k;
      localparam logic [1:0] KI = 2'(k);

      assign hit_k = link.wide ? (idx[1] == KI[1]) : (idx == KI);
      assign wr_k = take & link.we & ~bad & hit_k;
      assign data_k = (link.wide && KI[0] == 1'b0) ? link.wdata[15:8] : link.wdata[7:0];
      if (k == 2)
      begin : g_slp_mask
        // code and lock only load with the enable written as one
        assign mask_k = data_k[atb_pkg::SLP_EN_BIT] ? atb_pkg::SLP_LOAD_MASK
                                                    : atb_pkg::SLP_EN_MASK;
      end
      else
      begin : g_full_mask
        assign mask_k = atb_pkg::FULL_MASK;
      end

      // only reset clears them; low-power entry leaves them untouched
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          trim_r[k] <= atb_pkg::TRIM_RESET;
        else if (wr_k)
          trim_r[k] <= (trim_r[k] & ~mask_k) | (data_k & mask_k);
      end
    end
  endgenerate

  // analog sleep-bandgap trim, cleared only by power-on
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      ana_code_r <= atb_pkg::CODE_DEFAULT;
      ana_lock_r <= 1'b0;
    end
    else if (ce_i && !ana_lock_r && trim_r[2][atb_pkg::SLP_EN_BIT])
    begin
      ana_code_r <= trim_r[2][atb_pkg::SLP_CODE_LSB +: 3];
      ana_lock_r <= trim_r[2][atb_pkg::SLP_LOCK_BIT];
    end
  end

  // sleep trim output keeps the locked code across reset
  always_ff @(posedge clk_i)
  begin
    if (por_i)
    begin
      slp_code_r <= atb_pkg::CODE_DEFAULT;
      slp_locked_r <= 1'b0;
    end
    else if (ce_i)
    begin
      slp_locked_r <= ana_lock_r;
      if (ana_lock_r)
        slp_code_r <= ana_code_r;
      else if (trim_r[2][atb_pkg::SLP_EN_BIT])
        slp_code_r <= trim_r[2][atb_pkg::SLP_CODE_LSB +: 3];
      else
        slp_code_r <= atb_pkg::CODE_DEFAULT;
    end
  end

  assign sleep_bandgap_trim_code_o = slp_code_r;
  assign sleep_bandgap_locked_o = slp_locked_r;

  // watchdog adjustment in percent
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wd_pct_r <= 8'sd0;
    else if (ce_i)
      wd_pct_r <= trim_r[0][atb_pkg::WD_EN_BIT]
                  ? atb_pkg::wd_pct(trim_r[0][atb_pkg::WD_CODE_LSB +: 3]) : 8'sd0;
  end

  assign watchdog_clock_adjust_pct_o = wd_pct_r;

  // enable-gated outputs to the analog functions
  atb_trim_gate #(.W(1)) u_lin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(trim_r[0][atb_pkg::LIN_EN_BIT]),
    .field_i(trim_r[0][atb_pkg::LIN_SLOPE_BIT]),
    .trim_o(lin_slope_trim_o)
  );

  atb_trim_gate #(.W(3)) u_wd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(trim_r[0][atb_pkg::WD_EN_BIT]),
    .field_i(trim_r[0][atb_pkg::WD_CODE_LSB +: 3]),
    .trim_o(watchdog_clock_trim_code_o)
  );

  atb_trim_gate #(.W(2)) u_bg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(trim_r[1][atb_pkg::BG_EN_BIT]),
    .field_i({trim_r[1][atb_pkg::BG_UP_BIT], trim_r[1][atb_pkg::BG_DN_BIT]}),
    .trim_o({bandgap_slope_up_o, bandgap_slope_down_o})
  );

  atb_trim_gate #(.W(3)) u_iref (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(trim_r[1][atb_pkg::IREF_EN_BIT]),
    .field_i(trim_r[1][atb_pkg::IREF_CODE_LSB +: 3]),
    .trim_o(iref_trim_code_o)
  );

  atb_trim_gate #(.W(3)) u_adc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .en_i(trim_r[3][atb_pkg::ADC_EN_BIT]),
    .field_i(trim_r[3][atb_pkg::ADC_CODE_LSB +: 3]),
    .trim_o(adc_offset_trim_code_o)
  );
endmodule : atb_trim_bank

// file: pkg/atb_pkg.sv
// constants shared by the trim bank and its loader
package atb_pkg;
  // global address bases of the die-to-die window
  localparam logic [15:0] BASE_BLOCKING = 16'h0200;
  localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
  // trim register offsets
  localparam logic [7:0] OFS_LIN_WD = 8'hf0;
  localparam logic [7:0] OFS_BG_IREF = 8'hf1;
  localparam logic [7:0] OFS_SLPBG = 8'hf2;
  localparam logic [7:0] OFS_ADC = 8'hf3;
  localparam int TRIM_COUNT = 4;
  localparam logic [7:0] TRIM_RESET = 8'h00;
  // lin_watchdog_trim fields
  localparam int LIN_EN_BIT = 7;
  localparam int LIN_SLOPE_BIT = 6;
  localparam int WD_EN_BIT = 5;
  localparam int WD_CODE_LSB = 0;
  // bandgap_iref_trim fields
  localparam int BG_EN_BIT = 7;
  localparam int BG_UP_BIT = 5;
  localparam int BG_DN_BIT = 4;
  localparam int IREF_EN_BIT = 3;
  localparam int IREF_CODE_LSB = 0;
  // sleep_bandgap_trim fields
  localparam int SLP_EN_BIT = 4;
  localparam int SLP_LOCK_BIT = 3;
  localparam int SLP_CODE_LSB = 0;
  localparam logic [7:0] SLP_EN_MASK = 8'h10;
  localparam logic [7:0] SLP_LOAD_MASK = 8'h1f;
  localparam logic [7:0] FULL_MASK = 8'hff;
  // adc_offset_trim fields
  localparam int ADC_EN_BIT = 7;
  localparam int ADC_CODE_LSB = 4;
  // zero-trim code for every 3-bit field
  localparam logic [2:0] CODE_DEFAULT = 3'h0;
  // factory trim bytes in the protected flash info area
  localparam logic [19:0] FLASH_TRIM_BASE = 20'h040c0;
  localparam logic [7:0] PAGE_INFO_AREA = 8'h3f;
  // loader wishbone registers
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam logic [7:0] HREG_PAGE = 8'h08;
  localparam logic [7:0] HREG_TRIM = 8'h0c;
  localparam int CTRL_START = 0;
  localparam int CTRL_MASK_LOCK = 1;
  localparam int CTRL_WORD_MODE = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // watchdog base clock adjustment in percent for each trim code
  function automatic logic signed [7:0] wd_pct(input logic [2:0] code);
    case (code)
      3'h0: wd_pct = 8'sd0;
      3'h1: wd_pct = 8'sd5;
      3'h2: wd_pct = 8'sd10;
      3'h3: wd_pct = 8'sd15;
      3'h4: wd_pct = -8'sd20;
      3'h5: wd_pct = -8'sd15;
      3'h6: wd_pct = -8'sd10;
      default: wd_pct = -8'sd5;
    endcase
  endfunction : wd_pct
endpackage : atb_pkg

// file: pkg/atb_d2d_if.sv
// die-to-die register link between the loader and the trim bank
`timescale 1ns/1ps
interface atb_d2d_if;
  logic req;
  logic we;
  logic wide;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic ack;
  logic err;
  modport dev (input req, input we, input wide, input addr, input wdata, output rdata, output ack, output err);
  modport host (output req, output we, output wide, output addr, output wdata, input rdata, input ack, input err);
endinterface : atb_d2d_if

// file: core/atb_trim_gate.sv
// one enable-gated trim output, registered
`timescale 1ns/1ps
module atb_trim_gate #(
  parameter int W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic [W-1:0] field_i,
  output logic [W-1:0] trim_o
);
  // refuse a width the gate cannot carry
  if (W < 1)
  begin : g_bad_width
    $error("atb_trim_gate: W must be at least 1");
  end

  // zero-trim code unless the function is enabled
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trim_o <= '0;
    else if (ce_i)
      trim_o <= en_i ? field_i : '0;
  end
endmodule : atb_trim_gate

// file: core/atb_trim_loader.sv
// startup trim loader, host end of the die-to-die link
`timescale 1ns/1ps
module atb_trim_loader (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic flash_rd_o,
  output logic [19:0] flash_addr_o,
  input wire logic [7:0] flash_data_i,
  input wire logic flash_ack_i,
  output logic [7:0] program_page_index_o,
  atb_d2d_if.host link
);
  typedef enum logic [2:0] {ST_IDLE, ST_PAGE, ST_FREAD, ST_LINK, ST_DONE} atb_state_t;

  atb_state_t state_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic mask_lock_r;
  logic word_mode_r;
  logic done_r;
  logic err_r;
  logic [7:0] page_r;
  logic [7:0] page_out_r;
  logic [7:0] byte_r [0:atb_pkg::TRIM_COUNT-1];
  logic [1:0] cnt_r;
  logic flash_rd_r;
  logic link_req_r;
  logic link_wide_r;
  logic [15:0] link_addr_r;
  logic [15:0] link_wdata_r;
  logic wb_take;
  logic start;
  logic [7:0] slp_byte;
  logic [1:0] cnt_step;

  assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_r & ce_i;
  assign start = wb_take & wb_we_i & wb_sel_i[0] & (wb_adr_i == atb_pkg::HREG_CTRL)
                 & wb_dat_i[atb_pkg::CTRL_START] & (state_r == ST_IDLE);
  // lock bit masked off the sleep byte when asked
  assign slp_byte = mask_lock_r ? (byte_r[2] & ~(8'h01 << atb_pkg::SLP_LOCK_BIT)) : byte_r[2];
  assign cnt_step = word_mode_r ? 2'd2 : 2'd1;

  // wishbone slave: answer one cycle after the strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
      mask_lock_r <= 1'b0;
      word_mode_r <= 1'b0;
      page_r <= atb_pkg::PAGE_RESET;
    end
    else if (ce_i)
    begin
      wb_ack_r <= wb_take;
      if (wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == atb_pkg::HREG_CTRL && state_r == ST_IDLE)
      begin
        mask_lock_r <= wb_dat_i[atb_pkg::CTRL_MASK_LOCK];
        word_mode_r <= wb_dat_i[atb_pkg::CTRL_WORD_MODE];
      end
      if (wb_take && wb_we_i && wb_sel_i[0] && wb_adr_i == atb_pkg::HREG_PAGE)
        page_r <= wb_dat_i[7:0];
      if (wb_take && !wb_we_i)
      begin
        case (wb_adr_i)
          atb_pkg::HREG_CTRL: wb_dat_r <= {29'h0, word_mode_r, mask_lock_r, 1'b0};
          atb_pkg::HREG_STATUS: wb_dat_r <= {29'h0, err_r, done_r, state_r != ST_IDLE};
          atb_pkg::HREG_PAGE: wb_dat_r <= {24'h0, page_r};
          atb_pkg::HREG_TRIM: wb_dat_r <= {byte_r[3], byte_r[2], byte_r[1], byte_r[0]};
          default: wb_dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // copy sequence: open info area, read four bytes, write them to the bank
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 2'd0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      flash_rd_r <= 1'b0;
      link_req_r <= 1'b0;
      link_wide_r <= 1'b0;
      link_addr_r <= 16'h0000;
      link_wdata_r <= 16'h0000;
      page_out_r <= atb_pkg::PAGE_RESET;
      for (int i = 0; i < atb_pkg::TRIM_COUNT; i++)
        byte_r[i] <= 8'h00;
    end
    else if (ce_i)
    begin
      case (state_r)
        ST_IDLE:
        begin
          page_out_r <= page_r;
          if (start)
          begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            cnt_r <= 2'd0;
            page_out_r <= atb_pkg::PAGE_INFO_AREA;
            state_r <= ST_PAGE;
          end
        end
        ST_PAGE:
        begin
          flash_rd_r <= 1'b1;
          state_r <= ST_FREAD;
        end
        ST_FREAD:
        begin
          if (flash_ack_i)
          begin
            byte_r[cnt_r] <= flash_data_i;
            cnt_r <= cnt_r + 2'd1;
            if (cnt_r == 2'd3)
            begin
              flash_rd_r <= 1'b0;
              state_r <= ST_LINK;
            end
          end
        end
        ST_LINK:
        begin
          if (!link_req_r)
          begin
            link_req_r <= 1'b1;
            link_wide_r <= word_mode_r;
            link_addr_r <= atb_pkg::BASE_BLOCKING + {8'h00, atb_pkg::OFS_LIN_WD} + {14'h0, cnt_r};
            if (word_mode_r)
              link_wdata_r <= cnt_r[1] ? {slp_byte, byte_r[3]} : {byte_r[0], byte_r[1]};
            else
              link_wdata_r <= {8'h00, cnt_r == 2'd2 ? slp_byte : byte_r[cnt_r]};
          end
          else if (link.ack)
          begin
            link_req_r <= 1'b0;
            err_r <= err_r | link.err;
            cnt_r <= cnt_r + cnt_step;
            if (cnt_r + cnt_step == 2'd0)
              state_r <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          done_r <= 1'b1;
          page_out_r <= page_r;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  assign flash_rd_o = flash_rd_r;
  assign flash_addr_o = atb_pkg::FLASH_TRIM_BASE + {18'h0, cnt_r};
  assign program_page_index_o = page_out_r;
  assign link.req = link_req_r;
  assign link.we = link_req_r;
  assign link.wide = link_wide_r;
  assign link.addr = link_addr_r;
  assign link.wdata = link_wdata_r;
endmodule : atb_trim_loader

// file: test/atb_trim_monitor.sv
// link checker for the trim loader and trim bank
`timescale 1ns/1ps
module atb_trim_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic wide,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic ack,
  input wire logic err
);
  logic take;
  logic ok;
  assign take = req && !ack;
  assign ok = (addr[15:8] == 8'h02 || addr[15:8] == 8'h03) && addr[7:2] == 6'h3c && !(wide && addr[0]);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (take |=> ack)
    else $error("no ack after request");
  a_ack_single_pulse: assert property (ack |=> !ack)
    else $error("ack too long");
  a_err_needs_ack: assert property (err |-> ack)
    else $error("err without ack");
  a_bad_addr_err: assert property (take && !ok |=> err)
    else $error("bad access not refused");
  a_good_addr_ok: assert property (take && ok |=> !err)
    else $error("good access refused");
  a_write_only: assert property (req |-> we)
    else $error("request not a write");
  a_trim_window: assert property (req |-> addr[7:0] >= 8'hf0 && addr[7:0] <= 8'hf3)
    else $error("request outside trim window");
  a_word_even: assert property (req && wide |-> !addr[0])
    else $error("word at odd offset");
  a_req_released: assert property (ack |=> !req)
    else $error("request kept after ack");
  a_req_held: assert property (take |=> $stable(addr) && $stable(wdata) && $stable(wide))
    else $error("request changed before ack");
  c_byte_write: cover property (ack && !wide);
  c_word_write: cover property (ack && wide);
  c_sleep_write: cover property (ack && addr[7:0] == 8'hf2);
endmodule : atb_trim_monitor

// file: test/analog_trim_register_bank_tb_top.sv
// bench: loader copies modelled flash trim bytes into the trim bank
`timescale 1ns/1ps
module analog_trim_register_bank_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_rdat;
  logic wb_ack, flash_rd, lin_slope, bg_up, bg_dn, slp_lock;
  logic [19:0] flash_addr;
  logic [7:0] flash_data = 8'h00;
  logic flash_ack = 1'b0;
  logic [7:0] page;
  logic [2:0] wd_code, iref, slp_code, adc;
  logic signed [7:0] wd_pct;
  logic [7:0] fmem [4];
  logic [7:0] m [4];
  logic locked = 1'b0;
  logic [2:0] lcode = 3'h0;
  logic [1:0] stall = 2'h0;
  logic [15:0] lfsr_q = 16'h0051;
  int fidx = 0;
  int mismatches = 0;
  int cmp_count = 0;
  int pct [8] = '{0, 5, 10, 15, -20, -15, -10, -5};

  always #2.5 clk_i = ~clk_i;

  atb_d2d_if link ();
  atb_trim_bank atb_trim_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .ce_i(ce_i), .link(link.dev),
    .lin_slope_trim_o(lin_slope), .watchdog_clock_trim_code_o(wd_code), .watchdog_clock_adjust_pct_o(wd_pct),
    .bandgap_slope_up_o(bg_up), .bandgap_slope_down_o(bg_dn), .iref_trim_code_o(iref),
    .sleep_bandgap_trim_code_o(slp_code), .sleep_bandgap_locked_o(slp_lock), .adc_offset_trim_code_o(adc));
  atb_trim_loader atb_trim_loader_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .flash_rd_o(flash_rd), .flash_addr_o(flash_addr),
    .flash_data_i(flash_data), .flash_ack_i(flash_ack), .program_page_index_o(page), .link(link.host));
  atb_trim_monitor atb_trim_monitor_inst (.clk_i(clk_i), .rst_i(rst_i), .req(link.req), .we(link.we),
    .wide(link.wide), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack), .err(link.err));

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_step

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // flash model: one byte per ack, stalls at random, data churns when idle
  always @(posedge clk_i)
  begin
    stall <= stall + 2'h1;
    flash_ack <= 1'b0;
    flash_data <= ~flash_data;
    if (flash_rd === 1'b1 && !flash_ack && stall != lfsr_q[1:0])
    begin
      flash_ack <= 1'b1;
      flash_data <= fmem[flash_addr[1:0]];
      check(page, atb_pkg::PAGE_INFO_AREA, "page");
      check(flash_addr, atb_pkg::FLASH_TRIM_BASE + 20'(fidx), "flash addr");
      fidx++;
    end
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    // hold the request until ack is sampled high at a rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check(n < 50, 1, "wb ack");
  endtask : wb

  task automatic do_reset(input logic full);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_i <= full;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    por_i <= 1'b0;
    for (int i = 0; i < 4; i++) m[i] = 8'h00;
    if (full) locked = 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  task automatic outs(input string tname);
    check(lin_slope, m[0][7] & m[0][6], "lin slope");
    check(wd_code, m[0][5] ? m[0][2:0] : 3'h0, "wd code");
    check({{24{wd_pct[7]}}, wd_pct}, pct[m[0][5] ? m[0][2:0] : 3'h0], "wd pct");
    check({bg_up, bg_dn}, m[1][7] ? m[1][5:4] : 2'h0, "bg slope");
    check(iref, m[1][3] ? m[1][2:0] : 3'h0, "iref");
    check(adc, m[3][7] ? m[3][6:4] : 3'h0, "adc");
    check(slp_code, locked ? lcode : (m[2][4] ? m[2][2:0] : 3'h0), "sleep code");
    check(slp_lock, locked, "sleep lock");
    $display("test %s done", tname);
  endtask : outs

  task automatic load(input logic [31:0] b, input logic word, input logic mask);
    logic [31:0] r;
    logic [7:0] s;
    logic seen;
    int n;
    for (int i = 0; i < 4; i++) fmem[i] = b[8*i +: 8];
    fidx = 0;
    seen = 1'b0;
    n = 0;
    wb(1'b1, atb_pkg::HREG_CTRL, {29'h0, word, mask, 1'b1}, r);
    do
    begin
      wb(1'b0, atb_pkg::HREG_STATUS, 32'h0, r);
      seen = seen | r[0];
      n++;
    end
    while (!(seen && r[0] === 1'b0) && n < 100);
    check(r[2:0], 3'h2, "status");
    check(fidx, 4, "bytes read");
    wb(1'b0, atb_pkg::HREG_TRIM, 32'h0, r);
    check(r, b, "trim copy");
    s = mask ? b[23:16] & 8'hf7 : b[23:16];
    m[0] = b[7:0];
    m[1] = b[15:8];
    m[3] = b[31:24];
    if (s[4])
      m[2] = {3'h0, s[4:0]};
    else
      m[2] = {4'h0, m[2][3:0]};
    if (!locked && m[2][4] && m[2][3])
    begin
      locked = 1'b1;
      lcode = m[2][2:0];
    end
    repeat (2) @(posedge clk_i);
  endtask : load

  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    logic [31:0] r;
    logic [31:0] b;
    logic [7:0] pg;
    pg = lfsr_q[7:0];
    do_reset(1'b1);
    outs("reset");
    wb(1'b0, 8'h40, 32'h0, r);
    check(r, 32'h0, "unmapped read");
    wb(1'b1, atb_pkg::HREG_PAGE, {24'h0, pg}, r);
    wb(1'b0, atb_pkg::HREG_PAGE, 32'h0, r);
    check(r, {24'h0, pg}, "page reg");
    check(page, pg, "page idle");
    for (int i = 0; i < 8; i++)
    begin
      lfsr_q = lfsr_step(lfsr_q);
      b[31:16] = lfsr_q;
      lfsr_q = lfsr_step(lfsr_q);
      b[15:0] = lfsr_q;
      b[2:0] = i[2:0];
      b[5] = (i != 3);
      load(b, i[0], 1'b1);
      outs("codes");
    end
    check(page, pg, "page restored");
    @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce_i <= 1'b1;
    @(posedge clk_i);
    outs("low power hold");
    load(32'h9a1d8b2e, 1'b1, 1'b0);
    outs("lock set");
    load(32'h41165ce5, 1'b0, 1'b0);
    outs("lock held");
    do_reset(1'b0);
    outs("reset keeps lock");
    do_reset(1'b1);
    outs("power down");
    load(32'h031ea0f1, 1'b0, 1'b1);
    outs("lock masked");
    conclude();
  end
endmodule : analog_trim_register_bank_tb_top
